// file: pie_expander.sv
// Peripheral interrupt expander: pending flags, line routing, vectors
`timescale 1ns/10ps
`default_nettype none
module pie_expander
  import pie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic timer_b_period_irq,
  input wire logic timer_b_compare_irq,
  input wire logic timer_b_underflow_irq,
  input wire logic timer_b_overflow_irq,
  input wire logic timer_d_period_irq,
  input wire logic timer_d_compare_irq,
  input wire logic timer_d_underflow_irq,
  input wire logic timer_d_overflow_irq,
  input wire logic serial_periph_irq,
  input wire logic ext_pin_irq_a,
  input wire logic ext_pin_irq_b,
  input wire logic serial_hi_mode,
  input wire logic ext_pin_hi_mode,
  input wire logic ack_valid,
  input wire logic [1:0] ack_line,
  output logic cpu_line_one,
  output logic cpu_line_three,
  output logic cpu_line_five,
  output logic cpu_line_six,
  output logic ack_done,
  output logic [15:0] periph_vector,
  output logic [15:0] pending_row0,
  output logic [15:0] pending_row1,
  output logic [15:0] pending_row2
);
  localparam int N = PIE_SRC_COUNT;

  logic [N-1:0] req;
  logic [N-1:0] hi;
  logic [N-1:0] pend;
  logic [N-1:0] clr;
  logic [1:0] line_lo [N];
  logic [1:0] line_hi [N];
  logic [5:0] pri_lo [N];
  logic [5:0] pri_hi [N];
  logic [1:0] line [N];
  logic [5:0] pri [N];
  logic [15:0] vec [N];

  assign req = {ext_pin_irq_b, ext_pin_irq_a, serial_periph_irq,
                timer_d_overflow_irq, timer_d_underflow_irq,
                timer_d_compare_irq, timer_d_period_irq,
                timer_b_overflow_irq, timer_b_underflow_irq,
                timer_b_compare_irq, timer_b_period_irq};
  // Timers have no high-priority placement, so their mode bit is tied low
  assign hi = {ext_pin_hi_mode, ext_pin_hi_mode, serial_hi_mode, 8'h00};

  // Static routing table per source
  always_comb begin
    for (int i = 0; i < N; i++) begin
      line_lo[i] = PIE_LINE_THREE;
      line_hi[i] = PIE_LINE_THREE;
      pri_lo[i] = 6'h3F;
      pri_hi[i] = 6'h3F;
      vec[i] = PIE_VEC_PHANTOM;
    end
    pri_lo[PIE_SRC_TB_PRD] = PIE_PRI_TB_PRD;
    vec[PIE_SRC_TB_PRD] = PIE_VEC_TB_PRD;
    pri_lo[PIE_SRC_TB_CMP] = PIE_PRI_TB_CMP;
    vec[PIE_SRC_TB_CMP] = PIE_VEC_TB_CMP;
    pri_lo[PIE_SRC_TB_UF] = PIE_PRI_TB_UF;
    vec[PIE_SRC_TB_UF] = PIE_VEC_TB_UF;
    pri_lo[PIE_SRC_TB_OF] = PIE_PRI_TB_OF;
    vec[PIE_SRC_TB_OF] = PIE_VEC_TB_OF;
    pri_lo[PIE_SRC_TD_PRD] = PIE_PRI_TD_PRD;
    vec[PIE_SRC_TD_PRD] = PIE_VEC_TD_PRD;
    pri_lo[PIE_SRC_TD_CMP] = PIE_PRI_TD_CMP;
    vec[PIE_SRC_TD_CMP] = PIE_VEC_TD_CMP;
    pri_lo[PIE_SRC_TD_UF] = PIE_PRI_TD_UF;
    vec[PIE_SRC_TD_UF] = PIE_VEC_TD_UF;
    pri_lo[PIE_SRC_TD_OF] = PIE_PRI_TD_OF;
    vec[PIE_SRC_TD_OF] = PIE_VEC_TD_OF;
    line_lo[PIE_SRC_SPI] = PIE_LINE_FIVE;
    pri_lo[PIE_SRC_SPI] = PIE_PRI_SPI;
    vec[PIE_SRC_SPI] = PIE_VEC_SPI;
    line_hi[PIE_SRC_SPI] = PIE_LINE_ONE;
    pri_hi[PIE_SRC_SPI] = PIE_PRI_SPI_HI;
    line_lo[PIE_SRC_XA] = PIE_LINE_SIX;
    pri_lo[PIE_SRC_XA] = PIE_PRI_XA;
    vec[PIE_SRC_XA] = PIE_VEC_XA;
    line_hi[PIE_SRC_XA] = PIE_LINE_ONE;
    pri_hi[PIE_SRC_XA] = PIE_PRI_XA_HI;
    line_lo[PIE_SRC_XB] = PIE_LINE_SIX;
    pri_lo[PIE_SRC_XB] = PIE_PRI_XB;
    vec[PIE_SRC_XB] = PIE_VEC_XB;
    line_hi[PIE_SRC_XB] = PIE_LINE_ONE;
    pri_hi[PIE_SRC_XB] = PIE_PRI_XB_HI;
  end

  for (genvar g = 0; g < N; g++) begin : g_slot
    pie_src_slot u_slot (
      .sys_clk(sys_clk),
      .reset(reset),
      .req(req[g]),
      .clr(clr[g]),
      .hi_mode(hi[g]),
      .line_lo(line_lo[g]),
      .line_hi(line_hi[g]),
      .pri_lo(pri_lo[g]),
      .pri_hi(pri_hi[g]),
      .pend(pend[g]),
      .line(line[g]),
      .pri(pri[g])
    );
  end

  // Winner search on the acknowledged line; no winner gives phantom
  logic found;
  logic [5:0] best_pri;
  logic [15:0] best_vec;
  always_comb begin
    found = 1'b0;
    best_pri = 6'h3F;
    best_vec = PIE_VEC_PHANTOM;
    clr = '0;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && line[i] == ack_line && pri[i] <= best_pri) begin
        found = 1'b1;
        best_pri = pri[i];
        best_vec = vec[i];
      end
    end
    // Priorities are unique per mode, so only one source can match here
    for (int i = 0; i < N; i++) begin
      clr[i] = ack_valid && found && pend[i] && line[i] == ack_line &&
               pri[i] == best_pri;
    end
  end

  // Output registers
  logic [3:0] lines_d;
  logic [3:0] lines_q;
  logic ack_d;
  logic ack_q;
  logic [15:0] vec_d;
  logic [15:0] vec_q;
  logic [15:0] row0_d;
  logic [15:0] row1_d;
  logic [15:0] row2_d;
  logic [15:0] row0_q;
  logic [15:0] row1_q;
  logic [15:0] row2_q;

  // Lines drop at the acknowledge edge so the core never sees a stale
  // request; the pending image lags the flags by one cycle instead
  always_comb begin
    lines_d = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && !clr[i]) begin
        lines_d[line[i]] = 1'b1;
      end
    end
    ack_d = ack_valid;
    vec_d = ack_valid ? best_vec : vec_q;
    row0_d = PIE_REG_RESET;
    row1_d = PIE_REG_RESET;
    row2_d = PIE_REG_RESET;
    row1_d[PIE_R1_TB_PRD_BIT] = pend[PIE_SRC_TB_PRD];
    row1_d[PIE_R1_TB_CMP_BIT] = pend[PIE_SRC_TB_CMP];
    row1_d[PIE_R1_TB_UF_BIT] = pend[PIE_SRC_TB_UF];
    row1_d[PIE_R1_TB_OF_BIT] = pend[PIE_SRC_TB_OF];
    row2_d[PIE_R2_TD_PRD_BIT] = pend[PIE_SRC_TD_PRD];
    row2_d[PIE_R2_TD_CMP_BIT] = pend[PIE_SRC_TD_CMP];
    row2_d[PIE_R2_TD_UF_BIT] = pend[PIE_SRC_TD_UF];
    row2_d[PIE_R2_TD_OF_BIT] = pend[PIE_SRC_TD_OF];
    row1_d[PIE_R1_SPI_BIT] = pend[PIE_SRC_SPI] & ~serial_hi_mode;
    row0_d[PIE_R0_SPI_BIT] = pend[PIE_SRC_SPI] & serial_hi_mode;
    row1_d[PIE_R1_XA_BIT] = pend[PIE_SRC_XA] & ~ext_pin_hi_mode;
    // A mode switch moves a pending flag to its new row at the next clock edge
    row1_d[PIE_R1_XB_BIT] = pend[PIE_SRC_XB] & ~ext_pin_hi_mode;
    row0_d[PIE_R0_XA_BIT] = pend[PIE_SRC_XA] & ext_pin_hi_mode;
    row0_d[PIE_R0_XB_BIT] = pend[PIE_SRC_XB] & ext_pin_hi_mode;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lines_q <= 4'h0;
      ack_q <= 1'b0;
      vec_q <= PIE_VEC_PHANTOM;
      row0_q <= PIE_REG_RESET;
      row1_q <= PIE_REG_RESET;
      row2_q <= PIE_REG_RESET;
    end else begin
      lines_q <= lines_d;
      ack_q <= ack_d;
      vec_q <= vec_d;
      row0_q <= row0_d;
      row1_q <= row1_d;
      row2_q <= row2_d;
    end
  end

  assign cpu_line_one = lines_q[PIE_LINE_ONE];
  assign cpu_line_three = lines_q[PIE_LINE_THREE];
  assign cpu_line_five = lines_q[PIE_LINE_FIVE];
  assign cpu_line_six = lines_q[PIE_LINE_SIX];
  assign ack_done = ack_q;
  assign periph_vector = vec_q;
  assign pending_row0 = row0_q;
  assign pending_row1 = row1_q;
  assign pending_row2 = row2_q;
endmodule
`default_nettype wire

// file: pie_pkg.sv
// Package of constants for the peripheral interrupt expander
`default_nettype none
package pie_pkg;

  // Source indices into the request vector
  localparam int PIE_SRC_COUNT = 11;
  localparam int PIE_SRC_TB_PRD = 0;
  localparam int PIE_SRC_TB_CMP = 1;
  localparam int PIE_SRC_TB_UF = 2;
  localparam int PIE_SRC_TB_OF = 3;
  localparam int PIE_SRC_TD_PRD = 4;
  localparam int PIE_SRC_TD_CMP = 5;
  localparam int PIE_SRC_TD_UF = 6;
  localparam int PIE_SRC_TD_OF = 7;
  localparam int PIE_SRC_SPI = 8;
  localparam int PIE_SRC_XA = 9;
  localparam int PIE_SRC_XB = 10;

  // Pending register bit positions, row 0
  localparam int PIE_R0_XA_BIT = 2;
  localparam int PIE_R0_XB_BIT = 3;
  localparam int PIE_R0_SPI_BIT = 4;
  // Row 1
  localparam int PIE_R1_TB_PRD_BIT = 0;
  localparam int PIE_R1_TB_CMP_BIT = 1;
  localparam int PIE_R1_TB_UF_BIT = 2;
  localparam int PIE_R1_TB_OF_BIT = 3;
  localparam int PIE_R1_SPI_BIT = 7;
  localparam int PIE_R1_XA_BIT = 13;
  localparam int PIE_R1_XB_BIT = 14;
  // Row 2
  localparam int PIE_R2_TD_PRD_BIT = 8;
  localparam int PIE_R2_TD_CMP_BIT = 9;
  localparam int PIE_R2_TD_UF_BIT = 10;
  localparam int PIE_R2_TD_OF_BIT = 11;

  // Overall priorities, smaller number wins
  localparam logic [5:0] PIE_PRI_TB_PRD = 6'h1C;
  localparam logic [5:0] PIE_PRI_TB_CMP = 6'h1D;
  localparam logic [5:0] PIE_PRI_TB_UF = 6'h1E;
  localparam logic [5:0] PIE_PRI_TB_OF = 6'h1F;
  localparam logic [5:0] PIE_PRI_TD_PRD = 6'h20;
  localparam logic [5:0] PIE_PRI_TD_CMP = 6'h21;
  localparam logic [5:0] PIE_PRI_TD_UF = 6'h22;
  localparam logic [5:0] PIE_PRI_TD_OF = 6'h23;
  localparam logic [5:0] PIE_PRI_SPI = 6'h2A;
  localparam logic [5:0] PIE_PRI_XA = 6'h30;
  localparam logic [5:0] PIE_PRI_XB = 6'h31;
  // High-priority mode places these on line one ahead of the timers
  localparam logic [5:0] PIE_PRI_XA_HI = 6'h07;
  localparam logic [5:0] PIE_PRI_XB_HI = 6'h08;
  localparam logic [5:0] PIE_PRI_SPI_HI = 6'h09;

  // Peripheral vector codes
  localparam logic [15:0] PIE_VEC_TB_PRD = 16'h002B;
  localparam logic [15:0] PIE_VEC_TB_CMP = 16'h002C;
  localparam logic [15:0] PIE_VEC_TB_UF = 16'h002D;
  localparam logic [15:0] PIE_VEC_TB_OF = 16'h002E;
  localparam logic [15:0] PIE_VEC_TD_PRD = 16'h0039;
  localparam logic [15:0] PIE_VEC_TD_CMP = 16'h003A;
  localparam logic [15:0] PIE_VEC_TD_UF = 16'h003B;
  localparam logic [15:0] PIE_VEC_TD_OF = 16'h003C;
  localparam logic [15:0] PIE_VEC_SPI = 16'h0005;
  localparam logic [15:0] PIE_VEC_XA = 16'h0001;
  localparam logic [15:0] PIE_VEC_XB = 16'h0011;
  localparam logic [15:0] PIE_VEC_PHANTOM = 16'h0000;

  // CPU line vector addresses
  localparam logic [15:0] PIE_CPU_VEC_ONE = 16'h0002;
  localparam logic [15:0] PIE_CPU_VEC_THREE = 16'h0006;
  localparam logic [15:0] PIE_CPU_VEC_FIVE = 16'h000A;
  localparam logic [15:0] PIE_CPU_VEC_SIX = 16'h000C;

  // Line codes
  typedef enum logic [1:0] {
    PIE_LINE_ONE = 2'b00,
    PIE_LINE_THREE = 2'b01,
    PIE_LINE_FIVE = 2'b10,
    PIE_LINE_SIX = 2'b11
  } pie_line_t;

  localparam logic [15:0] PIE_REG_RESET = 16'h0000;

endpackage
`default_nettype wire

// file: pie_src_slot.sv
// One pending flag with its routing for the current mode
`timescale 1ns/10ps
`default_nettype none
module pie_src_slot
  import pie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req,
  input wire logic clr,
  input wire logic hi_mode,
  input wire logic [1:0] line_lo,
  input wire logic [1:0] line_hi,
  input wire logic [5:0] pri_lo,
  input wire logic [5:0] pri_hi,
  output logic pend,
  output logic [1:0] line,
  output logic [5:0] pri
);
  logic pend_q;
  logic pend_d;

  // A new request in the clear cycle wins so the event is not lost
  always_comb begin
    pend_d = (pend_q & ~clr) | req;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign pend = pend_q;
  assign line = hi_mode ? line_hi : line_lo;
  assign pri = hi_mode ? pri_hi : pri_lo;
endmodule
`default_nettype wire

// file: pie_expander_chk.sv
// Port checker for the peripheral interrupt expander
`timescale 1ns/10ps
`default_nettype none
module pie_expander_chk
  import pie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic timer_b_period_irq,
  input wire logic timer_d_overflow_irq,
  input wire logic serial_periph_irq,
  input wire logic ext_pin_irq_a,
  input wire logic serial_hi_mode,
  input wire logic ext_pin_hi_mode,
  input wire logic ack_valid,
  input wire logic [1:0] ack_line,
  input wire logic cpu_line_one,
  input wire logic cpu_line_three,
  input wire logic cpu_line_five,
  input wire logic cpu_line_six,
  input wire logic ack_done,
  input wire logic [15:0] periph_vector,
  input wire logic [15:0] pending_row0,
  input wire logic [15:0] pending_row1,
  input wire logic [15:0] pending_row2
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ack_done_follows: assert property (
    ack_valid |=> ack_done) else $error("ack_done missing");
  a_no_stray_done: assert property (
    !ack_valid |=> !ack_done) else $error("stray ack_done");
  a_tb_period_set: assert property (
    (timer_b_period_irq && !ack_valid) ##1 !ack_valid
    |=> pending_row1[0] && cpu_line_three) else $error("bit 1.0 not set");
  a_td_over_set: assert property (
    (timer_d_overflow_irq && !ack_valid) ##1 !ack_valid
    |=> pending_row2[11] && cpu_line_three) else $error("bit 2.11 not set");
  a_serial_high: assert property (
    (serial_periph_irq && !ack_valid && serial_hi_mode)
    ##1 (!ack_valid && serial_hi_mode)
    |=> pending_row0[4] && cpu_line_one) else $error("serial high route");
  a_serial_low: assert property (
    (serial_periph_irq && !ack_valid && !serial_hi_mode)
    ##1 (!ack_valid && !serial_hi_mode)
    |=> pending_row1[7] && cpu_line_five) else $error("serial low route");
  a_pin_a_low: assert property (
    (ext_pin_irq_a && !ack_valid && !ext_pin_hi_mode)
    ##1 (!ack_valid && !ext_pin_hi_mode)
    |=> pending_row1[13] && cpu_line_six) else $error("pin A low route");
  // After an acknowledge the line may drop one cycle before the image
  a_line_three_or: assert property (
    (!ack_done || cpu_line_three)
    |-> cpu_line_three == ((|pending_row1[3:0]) | (|pending_row2[11:8])))
    else $error("line three mismatch");
  a_best_vector: assert property (
    ack_valid && ack_line == PIE_LINE_THREE && pending_row1[0]
    && !$past(ack_valid) |=> periph_vector == PIE_VEC_TB_PRD)
    else $error("wrong winner vector");
endmodule
`default_nettype wire

// file: pie_cpu_model.sv
// Core side model: acknowledges a line and collects the vector
`timescale 1ns/10ps
`default_nettype none
module pie_cpu_model
  import pie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic ack_done,
  input wire logic [15:0] periph_vector,
  output logic ack_valid,
  output logic [1:0] ack_line,
  output logic got_done,
  output logic [15:0] got_vector
);
  initial begin
    ack_valid = 1'b0;
    ack_line = 2'h0;
    got_done = 1'b0;
    got_vector = 16'h0000;
  end
  // The pulse is one cycle long, so it is dropped after a single edge
  task automatic ack(input pie_line_t line, input int slow);
    repeat (slow) begin
      @(posedge sys_clk);
      #2;
    end
    ack_valid = 1'b1;
    ack_line = line;
    @(posedge sys_clk);
    #2;
    ack_valid = 1'b0;
    got_done = ack_done;
    got_vector = periph_vector;
    // Pending image lags the flags by one cycle
    @(posedge sys_clk);
    #2;
  endtask
endmodule
`default_nettype wire

// file: tb_pie_expander.sv
// Testbench for the peripheral interrupt expander
`timescale 1ns/10ps
`default_nettype none
module tb_pie_expander;
  import pie_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [10:0] irq = 11'h000;
  logic ser_hi = 1'b0;
  logic pin_hi = 1'b0;
  logic ack_valid, ack_done, got_done, l1, l3, l5, l6;
  logic [1:0] ack_line;
  logic [15:0] vec, got_vec, r0, r1, r2;
  int mismatches = 0;
  int compares = 0;
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  pie_expander pie_expander_inst (.sys_clk(sys_clk), .reset(reset),
    .timer_b_period_irq(irq[0]), .timer_b_compare_irq(irq[1]),
    .timer_b_underflow_irq(irq[2]), .timer_b_overflow_irq(irq[3]),
    .timer_d_period_irq(irq[4]), .timer_d_compare_irq(irq[5]),
    .timer_d_underflow_irq(irq[6]), .timer_d_overflow_irq(irq[7]),
    .serial_periph_irq(irq[8]), .ext_pin_irq_a(irq[9]),
    .ext_pin_irq_b(irq[10]), .serial_hi_mode(ser_hi),
    .ext_pin_hi_mode(pin_hi), .ack_valid(ack_valid),
    .ack_line(ack_line), .cpu_line_one(l1), .cpu_line_three(l3),
    .cpu_line_five(l5), .cpu_line_six(l6), .ack_done(ack_done),
    .periph_vector(vec), .pending_row0(r0), .pending_row1(r1),
    .pending_row2(r2));
  pie_cpu_model pie_cpu_model_inst (.sys_clk(sys_clk),
    .ack_done(ack_done), .periph_vector(vec), .ack_valid(ack_valid),
    .ack_line(ack_line), .got_done(got_done), .got_vector(got_vec));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic fire(input logic [10:0] m);
    irq = m;
    cyc(1);
    irq = 11'h000;
    cyc(2);
  endtask
  task automatic lines(input logic [3:0] exp);
    check({12'h000, l1, l3, l5, l6}, {12'h000, exp});
  endtask
  task automatic ack_chk(input pie_line_t ln, input logic [15:0] exp,
    input int slow);
    pie_cpu_model_inst.ack(ln, slow);
    check({15'h0000, got_done}, 16'h0001);
    check(got_vec, exp);
  endtask
  task automatic t_timers();
    fire(11'h0FF);
    check(r1, 16'h000F);
    check(r2, 16'h0F00);
    lines(4'h4);
    ack_chk(PIE_LINE_THREE, 16'h002B, 3);
    check(r1, 16'h000E);
    ack_chk(PIE_LINE_THREE, 16'h002C, 0);
    ack_chk(PIE_LINE_THREE, 16'h002D, 0);
    ack_chk(PIE_LINE_THREE, 16'h002E, 0);
    check(r1, 16'h0000);
    ack_chk(PIE_LINE_THREE, 16'h0039, 0);
    ack_chk(PIE_LINE_THREE, 16'h003A, 0);
    ack_chk(PIE_LINE_THREE, 16'h003B, 0);
    ack_chk(PIE_LINE_THREE, 16'h003C, 0);
    lines(4'h0);
    $display("timer test done");
  endtask
  task automatic t_low();
    fire(11'h700);
    check(r1, 16'h6080);
    lines(4'h3);
    ack_chk(PIE_LINE_FIVE, 16'h0005, 0);
    ack_chk(PIE_LINE_SIX, 16'h0001, 1);
    lines(4'h1);
    ack_chk(PIE_LINE_SIX, 16'h0011, 0);
    $display("low mode test done");
  endtask
  task automatic t_high();
    ser_hi = 1'b1;
    pin_hi = 1'b1;
    fire(11'h700);
    check(r0, 16'h001C);
    check(r1, 16'h0000);
    lines(4'h8);
    ack_chk(PIE_LINE_ONE, 16'h0001, 0);
    ack_chk(PIE_LINE_ONE, 16'h0011, 0);
    ack_chk(PIE_LINE_ONE, 16'h0005, 0);
    lines(4'h0);
    $display("high mode test done");
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    cyc(1);
    t_timers();
    t_low();
    t_high();
    report_and_stop();
  end
  // The three tests need well under 200 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end
endmodule
bind pie_expander pie_expander_chk pie_expander_chk_inst (
  .sys_clk(sys_clk),
  .reset(reset),
  .timer_b_period_irq(timer_b_period_irq),
  .timer_d_overflow_irq(timer_d_overflow_irq),
  .serial_periph_irq(serial_periph_irq),
  .ext_pin_irq_a(ext_pin_irq_a),
  .serial_hi_mode(serial_hi_mode),
  .ext_pin_hi_mode(ext_pin_hi_mode),
  .ack_valid(ack_valid),
  .ack_line(ack_line),
  .cpu_line_one(cpu_line_one),
  .cpu_line_three(cpu_line_three),
  .cpu_line_five(cpu_line_five),
  .cpu_line_six(cpu_line_six),
  .ack_done(ack_done),
  .periph_vector(periph_vector),
  .pending_row0(pending_row0),
  .pending_row1(pending_row1),
  .pending_row2(pending_row2)
);
`default_nettype wire
